/* File: logic/ufpc_defs.svh */
// Offsets, field positions, masks, reset values and counts of the block.
`ifndef UFPC_DEFS_SVH
`define UFPC_DEFS_SVH

`define UFPC_OFS_MAIN_CTRL 8'h00
`define UFPC_OFS_FRAME_PIN 8'h04
`define UFPC_OFS_STATUS 8'h08

`define UFPC_MAIN_ON_BIT 0
`define UFPC_MAIN_RX_BIT 1
`define UFPC_MAIN_MUTE_BIT 2
`define UFPC_MAIN_LEN_LSB 4
`define UFPC_MAIN_CTRL_MASK 32'h0000_0037

`define UFPC_STAT_MATCH_BIT 0
`define UFPC_STAT_BREAK_BIT 1

`define UFPC_FPC_RESET 32'h0000_0000
`define UFPC_MAIN_RESET 32'h0000_0000
`define UFPC_FPC_FREE_MASK 32'h0080_0040
`define UFPC_FPC_LOCK_MASK 32'h000F_FF30
`define UFPC_FPC_ADDR_MASK 32'hFF00_0000
`define UFPC_FPC_REDUCED_MASK 32'h0080_4060

`define UFPC_BRK_LEN_SHORT 4'hA
`define UFPC_BRK_LEN_LONG 4'hB

`define UFPC_STOP_HALVES_1 3'h2
`define UFPC_STOP_HALVES_0P5 3'h1
`define UFPC_STOP_HALVES_2 3'h4
`define UFPC_STOP_HALVES_1P5 3'h3

`endif

/* File: logic/ufpc_matcher.sv */
// Station address and character comparator.
`default_nettype none
module ufpc_matcher (
  input wire logic [7:0] i_addr,
  input wire logic i_full,
  input wire ufpc_pkg::ufpc_dlen_t i_dlen,
  input wire logic [8:0] i_frame,
  output logic o_is_addr,
  output logic o_addr_hit,
  output logic o_char_hit
);
  import ufpc_pkg::*;

  logic [7:0] key;
  logic [7:0] ref_val;

  // The top data bit marks an address frame; the rest, or only its low four bits when i_full is low, is the address.
  always_comb begin
    case (i_dlen)
      UFPC_LEN7: begin
        o_is_addr = i_frame[6];
        key = {2'h0, i_frame[5:0]};
        ref_val = {2'h0, i_addr[5:0]};
      end
      UFPC_LEN9: begin
        o_is_addr = i_frame[8];
        key = i_frame[7:0];
        ref_val = i_addr;
      end
      default: begin
        o_is_addr = i_frame[7];
        key = {1'h0, i_frame[6:0]};
        ref_val = {1'h0, i_addr[6:0]};
      end
    endcase
    if (!i_full) begin
      key = {4'h0, i_frame[3:0]};
      ref_val = {4'h0, i_addr[3:0]};
    end
    o_addr_hit = o_is_addr && (key == ref_val);
    o_char_hit = (i_frame[7:0] == i_addr);
  end

endmodule
`default_nettype wire

/* File: logic/ufpc_pkg.sv */
// Types shared by the frame and pin configuration block.
`default_nettype none
package ufpc_pkg;

  typedef enum logic [1:0] {
    UFPC_LEN8,
    UFPC_LEN9,
    UFPC_LEN7,
    UFPC_LENX
  } ufpc_dlen_t;

  typedef enum logic [1:0] {
    UFPC_BRK_IDLE,
    UFPC_BRK_LOW,
    UFPC_BRK_HELD
  } ufpc_brk_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ufpc_bus_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic rx_timeout_on;
    logic [2:0] rsv_22_20;
    logic bit_order_select;
    logic data_invert;
    logic tx_line_invert;
    logic rx_line_invert;
    logic pin_swap;
    logic lin_mode_on;
    logic [1:0] stop_length;
    logic clock_pin_on;
    logic clock_idle_level;
    logic clock_capture_phase;
    logic last_bit_pulse;
    logic rsv_7;
    logic break_irq_on;
    logic break_length_select;
    logic address_width_select;
    logic [3:0] rsv_3_0;
  } ufpc_ctl1_t;

endpackage
`default_nettype wire

/* File: logic/ufpc_top.sv */
// Frame and pin configuration word with its pin, match and break logic.
//
// The register addresses and strobed register access were decided locally.
`default_nettype none
`include "ufpc_defs.svh"
module ufpc_top #(
  parameter bit REDUCED = 1'b0
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire ufpc_pkg::ufpc_bus_req_t I_BUS,
  output logic [31:0] O_RDATA,
  input wire logic I_PIN_A,
  output logic O_PIN_A,
  output logic O_PIN_A_OE,
  input wire logic I_PIN_B,
  output logic O_PIN_B,
  output logic O_PIN_B_OE,
  input wire logic I_TX_LINE,
  input wire logic [8:0] I_TX_CHAR,
  output logic [8:0] O_TX_SHIFT,
  input wire logic [8:0] I_RX_SHIFT,
  input wire logic I_RX_VALID,
  output logic [8:0] O_RX_CHAR,
  output logic O_RX_LINE,
  input wire logic I_BIT_TICK,
  input wire logic I_CK_WINDOW,
  input wire logic I_CK_HALF,
  input wire logic I_CK_LAST,
  output logic O_CK,
  output logic O_CK_OE,
  output logic [2:0] O_STOP_HALVES,
  output logic O_RX_TIMEOUT_ON,
  output logic O_BREAK_IRQ,
  output logic O_WAKE
);
  import ufpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [31:0] fpc_q, fpc_d;
  logic [31:0] main_q, main_d;
  logic [1:0] stat_q, stat_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] wmask;
  ufpc_ctl1_t cfg;
  logic periph_on, rx_on, mute_on;
  ufpc_dlen_t dlen;
  logic set_match, set_break;

  assign cfg = ufpc_ctl1_t'(fpc_q);
  assign periph_on = main_q[`UFPC_MAIN_ON_BIT];
  assign rx_on = main_q[`UFPC_MAIN_RX_BIT];
  assign mute_on = main_q[`UFPC_MAIN_MUTE_BIT];
  assign dlen = ufpc_dlen_t'(main_q[`UFPC_MAIN_LEN_LSB +: 2]);

  always_comb begin
    wmask = `UFPC_FPC_FREE_MASK;
    if (!periph_on) begin
      wmask = wmask | `UFPC_FPC_LOCK_MASK;
    end
    if (!(periph_on && rx_on)) begin
      wmask = wmask | `UFPC_FPC_ADDR_MASK;
    end
    if (REDUCED) begin
      wmask = wmask & ~`UFPC_FPC_REDUCED_MASK;
    end
  end

  // Reserved bits never reach the store, so they always read as zero.
  always_comb begin
    fpc_d = fpc_q;
    main_d = main_q;
    stat_d = stat_q;
    rdata_d = 32'h0000_0000;
    if (I_BUS.wr) begin
      if (I_BUS.addr == `UFPC_OFS_FRAME_PIN) begin
        fpc_d = (I_BUS.wdata & wmask) | (fpc_q & ~wmask);
      end else if (I_BUS.addr == `UFPC_OFS_MAIN_CTRL) begin
        main_d = I_BUS.wdata & `UFPC_MAIN_CTRL_MASK;
      end else if (I_BUS.addr == `UFPC_OFS_STATUS) begin
        stat_d = stat_q & ~I_BUS.wdata[1:0];
      end
    end
    // A flag event in the clearing cycle keeps the flag set.
    stat_d[`UFPC_STAT_MATCH_BIT] = stat_d[`UFPC_STAT_MATCH_BIT] | set_match;
    stat_d[`UFPC_STAT_BREAK_BIT] = stat_d[`UFPC_STAT_BREAK_BIT] | set_break;
    if (I_BUS.rd) begin
      if (I_BUS.addr == `UFPC_OFS_FRAME_PIN) begin
        rdata_d = fpc_q;
      end else if (I_BUS.addr == `UFPC_OFS_MAIN_CTRL) begin
        rdata_d = main_q;
      end else if (I_BUS.addr == `UFPC_OFS_STATUS) begin
        rdata_d = {30'h0, stat_q};
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      fpc_q <= `UFPC_FPC_RESET;
      main_q <= `UFPC_MAIN_RESET;
      stat_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      fpc_q <= fpc_d;
      main_q <= main_d;
      stat_q <= stat_d;
      rdata_q <= rdata_d;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_BREAK_IRQ = stat_q[`UFPC_STAT_BREAK_BIT] & cfg.break_irq_on;
  assign O_RX_TIMEOUT_ON = cfg.rx_timeout_on;

  ////////////////////////////////////////////////////////////////////////////
  // Pins, line inversion and receive synchroniser.

  logic sync1_q, sync2_q, sync3_q, rx_lvl_q, rx_lvl_d;
  logic tx_pin_q, tx_pin_d, ck_q, ck_d;
  logic [2:0] stop_q, stop_d;
  logic ck_active;

  always_comb begin
    rx_lvl_d = rx_lvl_q;
    if (sync2_q == sync3_q) begin
      rx_lvl_d = sync3_q ^ cfg.rx_line_invert;
    end
    tx_pin_d = I_TX_LINE ^ cfg.tx_line_invert;
    ck_active = cfg.clock_capture_phase ? !I_CK_HALF : I_CK_HALF;
    if (I_CK_LAST && !cfg.last_bit_pulse) begin
      ck_active = 1'b0;
    end
    ck_d = cfg.clock_idle_level;
    if (I_CK_WINDOW && cfg.clock_pin_on) begin
      ck_d = cfg.clock_idle_level ^ ck_active;
    end
    case (cfg.stop_length)
      2'h0: stop_d = `UFPC_STOP_HALVES_1;
      2'h1: stop_d = `UFPC_STOP_HALVES_0P5;
      2'h2: stop_d = `UFPC_STOP_HALVES_2;
      default: stop_d = `UFPC_STOP_HALVES_1P5;
    endcase
  end

  // The swap is only changed while disabled, so muxing ahead of the
  // synchroniser cannot produce a glitch that matters.
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
      rx_lvl_q <= 1'b1;
      tx_pin_q <= 1'b1;
      ck_q <= 1'b0;
      stop_q <= `UFPC_STOP_HALVES_1;
    end else begin
      sync1_q <= cfg.pin_swap ? I_PIN_A : I_PIN_B;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      rx_lvl_q <= rx_lvl_d;
      tx_pin_q <= tx_pin_d;
      ck_q <= ck_d;
      stop_q <= stop_d;
    end
  end

  assign O_PIN_A = tx_pin_q;
  assign O_PIN_B = tx_pin_q;
  assign O_PIN_A_OE = periph_on & !cfg.pin_swap;
  assign O_PIN_B_OE = periph_on & cfg.pin_swap;
  assign O_RX_LINE = rx_lvl_q;
  assign O_CK = ck_q;
  assign O_CK_OE = periph_on & cfg.clock_pin_on;
  assign O_STOP_HALVES = stop_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bit order and data inversion of whole characters.

  logic [8:0] rx_rev, tx_rev, rx_ord, tx_ord, dmask;
  logic [8:0] rx_char_q, tx_shift_q;

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_rev
      assign rx_rev[gi] = I_RX_SHIFT[8 - gi];
      assign tx_rev[gi] = I_TX_CHAR[8 - gi];
    end
  endgenerate

  always_comb begin
    rx_ord = I_RX_SHIFT;
    tx_ord = I_TX_CHAR;
    case (dlen)
      UFPC_LEN9: dmask = 9'h1FF;
      UFPC_LEN7: dmask = 9'h07F;
      default: dmask = 9'h0FF;
    endcase
    if (cfg.bit_order_select) begin
      case (dlen)
        UFPC_LEN9: begin
          rx_ord = rx_rev;
          tx_ord = tx_rev;
        end
        UFPC_LEN7: begin
          rx_ord = {2'h0, rx_rev[8:2]};
          tx_ord = {2'h0, tx_rev[8:2]};
        end
        default: begin
          rx_ord = {1'h0, rx_rev[8:1]};
          tx_ord = {1'h0, tx_rev[8:1]};
        end
      endcase
    end
    if (cfg.data_invert) begin
      rx_ord = rx_ord ^ dmask;
      tx_ord = tx_ord ^ dmask;
    end
    rx_ord = rx_ord & dmask;
    tx_ord = tx_ord & dmask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and character matching.

  logic is_addr, addr_hit, char_hit, wake_q, wake_d, take;

  ufpc_matcher i_ufpc_matcher (
    .i_addr(cfg.addr),
    .i_full(cfg.address_width_select),
    .i_dlen(dlen),
    .i_frame(rx_ord),
    .o_is_addr(is_addr),
    .o_addr_hit(addr_hit),
    .o_char_hit(char_hit)
  );

  assign take = I_RX_VALID && periph_on && rx_on;
  assign set_match = take && !mute_on && char_hit;
  assign wake_d = take && mute_on && addr_hit;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rx_char_q <= 9'h000;
      tx_shift_q <= 9'h000;
      wake_q <= 1'b0;
    end else begin
      if (take) begin
        rx_char_q <= rx_ord;
      end
      tx_shift_q <= tx_ord;
      wake_q <= wake_d;
    end
  end

  assign O_RX_CHAR = rx_char_q;
  assign O_TX_SHIFT = tx_shift_q;
  assign O_WAKE = wake_q;

  ////////////////////////////////////////////////////////////////////////////
  // Break detection on the conditioned receive line.

  ufpc_brk_state_t brk_q, brk_d;
  logic [3:0] cnt_q, cnt_d, brk_len;

  assign brk_len = cfg.break_length_select ?
                   `UFPC_BRK_LEN_LONG : `UFPC_BRK_LEN_SHORT;

  always_comb begin
    brk_d = brk_q;
    cnt_d = cnt_q;
    set_break = 1'b0;
    if (!(cfg.lin_mode_on && periph_on && rx_on) || rx_lvl_q) begin
      brk_d = UFPC_BRK_IDLE;
      cnt_d = 4'h0;
    end else if (I_BIT_TICK) begin
      case (brk_q)
        UFPC_BRK_IDLE,
        UFPC_BRK_LOW: begin
          cnt_d = cnt_q + 4'h1;
          brk_d = UFPC_BRK_LOW;
          if (cnt_d == brk_len) begin
            set_break = 1'b1;
            brk_d = UFPC_BRK_HELD;
          end
        end
        default: brk_d = UFPC_BRK_HELD;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      brk_q <= UFPC_BRK_IDLE;
      cnt_q <= 4'h0;
    end else begin
      brk_q <= brk_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  AST_MATCH_SETS: assert property (
    set_match |=> stat_q[`UFPC_STAT_MATCH_BIT])
    else $error("match flag not set after character match");
  AST_WAKE: assert property (
    (take && mute_on && addr_hit) |=> O_WAKE)
    else $error("wake pulse missing after address match");
  AST_ADDR_LOCK: assert property (
    (I_BUS.wr && I_BUS.addr == `UFPC_OFS_FRAME_PIN && periph_on && rx_on)
    |=> fpc_q[31:24] == $past(fpc_q[31:24]))
    else $error("address changed while locked");
  AST_FIELD_LOCK: assert property (
    (I_BUS.wr && I_BUS.addr == `UFPC_OFS_FRAME_PIN && periph_on)
    |=> fpc_q[19:8] == $past(fpc_q[19:8]))
    else $error("frame setting changed while enabled");
  AST_TX_INV: assert property (
    ##1 O_PIN_A == ($past(I_TX_LINE) ^ $past(cfg.tx_line_invert)))
    else $error("transmit pin level wrong");
  AST_CK_IDLE: assert property (
    (!I_CK_WINDOW || !cfg.clock_pin_on)
    |=> O_CK == $past(cfg.clock_idle_level))
    else $error("clock pin not at idle level");
  AST_BRK_IRQ: assert property (
    set_break |=> O_BREAK_IRQ == cfg.break_irq_on)
    else $error("break interrupt missing");
  AST_BRK_LEN: assert property (
    set_break |-> cnt_q + 4'h1 == (cfg.break_length_select ?
      `UFPC_BRK_LEN_LONG : `UFPC_BRK_LEN_SHORT))
    else $error("break detected at wrong length");
  AST_REDUCED: assert property (
    REDUCED |-> (fpc_q & `UFPC_FPC_REDUCED_MASK) == 32'h0000_0000)
    else $error("reserved bits set in reduced instance");
  AST_RDATA_ZERO: assert property (
    (I_BUS.rd && I_BUS.addr > `UFPC_OFS_STATUS) |=> O_RDATA == 32'h0000_0000)
    else $error("unmapped read returned data");

  COV_MATCH: cover property (set_match);
  COV_WAKE: cover property (O_WAKE);
  COV_BREAK: cover property (set_break ##1 O_BREAK_IRQ);
  COV_SWAP: cover property (O_PIN_B_OE);

endmodule
`default_nettype wire

/* File: tb/ufpc_remote.sv */
// Remote transceiver seen through the transmit and receive pin wires.
`default_nettype none
module ufpc_remote (
  input wire logic i_swapped,
  input wire logic i_send,
  input wire logic i_a_o,
  input wire logic i_a_oe,
  input wire logic i_b_o,
  input wire logic i_b_oe,
  output logic o_a,
  output logic o_b,
  output logic o_heard
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released wire floats to the idle mark level through its pull-up.
  // The remote drives whichever pin currently acts as our receive input.
  assign o_a = i_a_oe ? i_a_o : (i_swapped ? i_send : 1'b1);
  assign o_b = i_b_oe ? i_b_o : (i_swapped ? 1'b1 : i_send);
  assign o_heard = i_swapped ? o_b : o_a;
endmodule
`default_nettype wire

/* File: tb/ufpc_top_bench.sv */
// Directed bench for the frame and pin configuration block.
`default_nettype none
`include "ufpc_defs.svh"
module ufpc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ufpc_pkg::*;
  localparam logic [7:0] MC = `UFPC_OFS_MAIN_CTRL;
  localparam logic [7:0] FP = `UFPC_OFS_FRAME_PIN;
  localparam logic [7:0] ST = `UFPC_OFS_STATUS;
  logic clk, rst_n, swp, snd, tx_line, rxv, tick, ckw, ckh, ckl;
  logic pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe, heard, rx_line, ck, ck_oe;
  logic tmo_on, irq, wake, tmo_r, irq_r;
  logic [31:0] rdata_r;
  logic [8:0] txc, rxs, tx_shift, rx_char;
  logic [31:0] rdata, v;
  logic [2:0] stop;
  logic [2:0] halves [4] = '{`UFPC_STOP_HALVES_1, `UFPC_STOP_HALVES_0P5,
    `UFPC_STOP_HALVES_2, `UFPC_STOP_HALVES_1P5};
  ufpc_bus_req_t bus;
  int err_total, n_compared, cyc;

  ufpc_top i_ufpc_top (.I_CLK(clk), .I_RST_N(rst_n), .I_BUS(bus),
    .O_RDATA(rdata), .I_PIN_A(pa_i), .O_PIN_A(pa_o), .O_PIN_A_OE(pa_oe),
    .I_PIN_B(pb_i), .O_PIN_B(pb_o), .O_PIN_B_OE(pb_oe),
    .I_TX_LINE(tx_line), .I_TX_CHAR(txc), .O_TX_SHIFT(tx_shift),
    .I_RX_SHIFT(rxs), .I_RX_VALID(rxv), .O_RX_CHAR(rx_char),
    .O_RX_LINE(rx_line), .I_BIT_TICK(tick), .I_CK_WINDOW(ckw),
    .I_CK_HALF(ckh), .I_CK_LAST(ckl), .O_CK(ck), .O_CK_OE(ck_oe),
    .O_STOP_HALVES(stop), .O_RX_TIMEOUT_ON(tmo_on), .O_BREAK_IRQ(irq),
    .O_WAKE(wake));
  ufpc_remote i_ufpc_remote (.i_swapped(swp), .i_send(snd), .i_a_o(pa_o),
    .i_a_oe(pa_oe), .i_b_o(pb_o), .i_b_oe(pb_oe), .o_a(pa_i), .o_b(pb_i),
    .o_heard(heard));
  // Reduced instance on the same stimulus, watched only where it differs.
  ufpc_top #(.REDUCED(1'b1)) i_ufpc_top_rdc (.I_CLK(clk), .I_RST_N(rst_n),
    .I_BUS(bus), .O_RDATA(rdata_r), .I_PIN_A(pa_i), .O_PIN_A(),
    .O_PIN_A_OE(), .I_PIN_B(pb_i), .O_PIN_B(), .O_PIN_B_OE(),
    .I_TX_LINE(tx_line), .I_TX_CHAR(txc), .O_TX_SHIFT(), .I_RX_SHIFT(rxs),
    .I_RX_VALID(rxv), .O_RX_CHAR(), .O_RX_LINE(), .I_BIT_TICK(tick),
    .I_CK_WINDOW(ckw), .I_CK_HALF(ckh), .I_CK_LAST(ckl), .O_CK(),
    .O_CK_OE(), .O_STOP_HALVES(), .O_RX_TIMEOUT_ON(tmo_r),
    .O_BREAK_IRQ(irq_r), .O_WAKE());

  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic chkr(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk);
    bus <= '0;
    #1 chk(rdata, exp);
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rxchar(input logic [8:0] s);
    @(posedge clk);
    rxs <= s;
    rxv <= 1'b1;
    @(posedge clk);
    rxv <= 1'b0;
    #1;
  endtask
  task automatic pulse_tick();
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask
  task automatic ckq(input logic w, input logic h, input logic l,
                     input logic exp);
    @(posedge clk);
    ckw <= w;
    ckh <= h;
    ckl <= l;
    cyc_n(2);
    chk(ck, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A hang is cut short well after the directed sequence should be done.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    {rst_n, swp, rxv, tick, ckw, ckh, ckl} = '0;
    {snd, tx_line} = 2'b11;
    txc = '0;
    rxs = '0;
    bus = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(stop, `UFPC_STOP_HALVES_1);
    chkr(8'h0C, 32'h0000_0000);
    wr(8'h0C, 32'h0000_00FF);
    chkr(8'h0C, 32'h0000_0000);
    wr(FP, 32'hFF8F_FF70);
    chkr(FP, 32'hFF8F_FF70);
    chk(rdata_r, 32'hFF0F_BF10);
    chk(tmo_on, 1'b1);
    chk(tmo_r, 1'b0);
    for (int s = 0; s < 4; s++) begin
      wr(FP, 32'(s) << 12);
      cyc_n(2);
      chk(stop, halves[s]);
    end
    chk(tmo_on, 1'b0);
    wr(FP, 32'h0002_8000);
    wr(MC, 32'h0000_0001);
    @(posedge clk);
    swp <= 1'b1;
    tx_line <= 1'b0;
    cyc_n(2);
    chk({pa_oe, pb_oe}, 2'b01);
    chk(heard, 1'b1);
    wr(MC, 32'h0000_0000);
    wr(FP, 32'h0001_0000);
    wr(MC, 32'h0000_0001);
    @(posedge clk);
    swp <= 1'b0;
    snd <= 1'b0;
    cyc_n(6);
    chk(rx_line, 1'b1);
    chk(heard, 1'b0);
    wr(FP, 32'hFF8F_FF70);
    chkr(FP, 32'hFF81_0040);
    wr(MC, 32'h0000_0003);
    wr(FP, 32'h0001_0000);
    chkr(FP, 32'hFF01_0000);
    wr(MC, 32'h0000_0000);
    wr(FP, 32'h350C_0000);
    wr(MC, 32'h0000_0003);
    @(posedge clk);
    snd <= 1'b1;
    txc <= 9'h001;
    rxchar(9'h053);
    chk(rx_char, 9'h035);
    chk(tx_shift, 9'h07F);
    chkr(ST, 32'h0000_0001);
    wr(ST, 32'h0000_0001);
    chkr(ST, 32'h0000_0000);
    wr(MC, 32'h0000_0000);
    wr(FP, 32'h0300_0000);
    wr(MC, 32'h0000_0007);
    rxchar(9'h0A3);
    chk(wake, 1'b1);
    cyc_n(1);
    chk(wake, 1'b0);
    wr(MC, 32'h0000_0000);
    wr(FP, 32'h0300_0010);
    wr(MC, 32'h0000_0007);
    rxchar(9'h093);
    chk(wake, 1'b0);
    rxchar(9'h083);
    chk(wake, 1'b1);
    wr(MC, 32'h0000_0027);
    rxchar(9'h043);
    chk(wake, 1'b1);
    chkr(ST, 32'h0000_0000);
    wr(MC, 32'h0000_0000);
    wr(FP, 32'h0000_4060);
    wr(MC, 32'h0000_0003);
    @(posedge clk);
    snd <= 1'b0;
    cyc_n(6);
    repeat (10) pulse_tick();
    chkr(ST, 32'h0000_0000);
    pulse_tick();
    chkr(ST, 32'h0000_0002);
    chk(irq, 1'b1);
    chk(irq_r, 1'b0);
    @(posedge clk);
    snd <= 1'b1;
    wr(ST, 32'h0000_0002);
    cyc_n(1);
    chk(irq, 1'b0);
    wr(MC, 32'h0000_0000);
    wr(FP, 32'h0000_0C00);
    wr(MC, 32'h0000_0001);
    ckq(1'b0, 1'b0, 1'b0, 1'b1);
    chk(ck_oe, 1'b1);
    ckq(1'b1, 1'b1, 1'b0, 1'b0);
    ckq(1'b1, 1'b1, 1'b1, 1'b1);
    wr(MC, 32'h0000_0000);
    wr(FP, 32'h0000_0F00);
    wr(MC, 32'h0000_0001);
    ckq(1'b1, 1'b0, 1'b0, 1'b0);
    ckq(1'b1, 1'b1, 1'b0, 1'b1);
    ckq(1'b1, 1'b0, 1'b1, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
